// File: hw/sid_pkg.sv
// shared constants for the step interpolator and diagnostic block
package sid_pkg;
  localparam int SID_INTERP_RES = 256;
  localparam int SID_INTERP_LOG2 = 8;
  localparam int SID_SENS_SHIFT = 4;
  localparam logic [3:0] SID_MRES_MAX = 4'h8;
  localparam int SID_MSCNT_W = 10;
  localparam int SID_ITV_W = 20;
  localparam int SID_STST_LOG2 = 20;
  localparam int SID_STST_FAST_LOG2 = 18;
  localparam logic [3:0] SID_OFF_TIME_LOAD_MAX = 4'h8;
  localparam logic [23:0] SID_VDC_OFF = 24'h000000;
  localparam logic [2:0] SID_SRC_STALL = 3'h0;
  localparam logic [2:0] SID_SRC_INDEX = 3'h1;
  localparam logic [2:0] SID_SRC_CHOP_ON = 3'h2;
  localparam logic [2:0] SID_SRC_SKIP = 3'h3;
  localparam logic [2:0] SID_SRC_STST = 3'h4;
  localparam logic [9:0] SID_MSCNT_ZERO = 10'h000;
endpackage

// File: hw/sid_diag_pin.sv
`timescale 1ns/1ps
// one configurable diagnostic pin: source select, force low, drive type
module sid_diag_pin
  import sid_pkg::*;
(
  input wire logic [2:0] src_sel_i,
  input wire logic [4:0] src_vec_i,
  input wire logic push_pull_i,
  input wire logic force_low_i,
  output logic pin_o,
  output logic pin_oe_o
);
  logic active;
  logic src_bit;
  // unused source codes read as inactive
  assign src_bit = (src_sel_i <= SID_SRC_STST) ? src_vec_i[src_sel_i] : 1'b0;
  assign active = src_bit & ~force_low_i;
  // open drain pulls low when active; push-pull drives active high
  assign pin_o = force_low_i ? 1'b0 : (push_pull_i ? active : 1'b0);
  assign pin_oe_o = force_low_i | push_pull_i | active;
endmodule // sid_diag_pin

// File: hw/sid_step_interpolator.sv
`timescale 1ns/1ps
// step interpolation, standstill detection and diagnostic outputs
module sid_step_interpolator
  import sid_pkg::*;
#(
  parameter int STST_LOG2 = SID_STST_LOG2,
  parameter int STST_FAST_LOG2 = SID_STST_FAST_LOG2
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic por_active_i,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic intpol_en_i,
  input wire logic dedge_i,
  input wire logic fast_standstill_i,
  input wire logic [3:0] mres_i,
  input wire logic [4:0] run_current_i,
  input wire logic [4:0] holding_current_i,
  input wire logic quiet_chop_en_i,
  input wire logic load_mode_en_i,
  input wire logic vhigh_fs_i,
  input wire logic vhigh_chm_i,
  input wire logic [3:0] off_time_i,
  input wire logic [22:0] min_commutation_velocity_i,
  input wire logic [22:0] velocity_i,
  input wire logic [9:0] load_ref_pulse_width_i,
  input wire logic [7:0] load_mode_stall_sens_i,
  input wire logic [9:0] load_value_i,
  input wire logic motor_ready_i,
  input wire logic coil_a_on_i,
  input wire logic coil_b_on_i,
  input wire logic [2:0] diag0_src_i,
  input wire logic diag0_pp_i,
  input wire logic [2:0] diag_out_one_src_i,
  input wire logic diag_out_one_pp_i,
  output logic [9:0] mscnt_o,
  output logic microstep_o,
  output logic standstill_o,
  output logic [4:0] current_setpoint_o,
  output logic load_mode_active_o,
  output logic fullstep_o,
  output logic [3:0] eff_off_time_o,
  output logic [8:0] load_value_o,
  output logic stall_o,
  output logic diag_out_zero_o,
  output logic diag_out_zero_oe_o,
  output logic diag_out_one_o,
  output logic diag_out_one_oe_o
);
  // synchronised pins
  logic step_s1;
  logic step_s2;
  logic step_s3;
  logic dir_s1;
  logic dir_s2;

  // step interval timing and interpolation
  logic [SID_ITV_W-1:0] itv_cnt;
  logic [SID_ITV_W-1:0] last_itv;
  logic [SID_ITV_W-1:0] sub_cnt;
  logic [8:0] ms_left;
  logic standstill;

  // microstep position and diagnostic sources
  logic [9:0] mscnt;
  logic index_q;
  logic skip_tgl;
  logic chop_sel;
  logic chop_on;

  // load-dependent commutation state
  logic [8:0] load_value;
  logic [9:0] stall_cnt;
  logic stall;
  logic [4:0] cur_q;
  logic load_active_q;
  logic fullstep_q;

  // falling edge counts only with both-edge stepping
  wire logic rise = step_s2 & ~step_s3;
  wire logic fall = ~step_s2 & step_s3;
  wire logic step_edge = rise | (dedge_i & fall);

  // microsteps per input step, clamped at full step width
  wire logic [3:0] mres_eff = (mres_i > SID_MRES_MAX)
    ? SID_MRES_MAX : mres_i;
  wire logic [8:0] step_width =
    9'(SID_INTERP_RES >> (SID_INTERP_LOG2 - int'(mres_eff)));
  wire logic [SID_ITV_W-1:0] sub_period = last_itv >> SID_INTERP_LOG2;
  wire logic [SID_ITV_W-1:0] st_limit = fast_standstill_i
    ? SID_ITV_W'((64'h1 << STST_FAST_LOG2) - 64'h1)
    : SID_ITV_W'((64'h1 << STST_LOG2) - 64'h1);
  wire logic st_expired = itv_cnt >= st_limit;

  // load-dependent commutation qualification
  wire logic interp = intpol_en_i & ~load_active_q;
  wire logic vdc_on =
    {1'b0, min_commutation_velocity_i} != SID_VDC_OFF;
  wire logic load_ok = load_mode_en_i & ~quiet_chop_en_i & vdc_on
    & vhigh_fs_i & vhigh_chm_i;
  wire logic above_vdc = velocity_i >= min_commutation_velocity_i;
  wire logic load_enter = load_ok & above_vdc;

  // microstep stepping
  wire logic sub_tick = interp & (ms_left != 9'h000)
    & (sub_cnt >= sub_period);
  wire logic skip_step = load_active_q & ~motor_ready_i & step_edge;
  wire logic exec_direct = step_edge & ~interp & ~skip_step;
  wire logic [9:0] move = exec_direct ? {1'b0, step_width} : 10'h001;
  wire logic do_move = exec_direct | sub_tick;
  wire logic [9:0] next_mscnt = dir_s2 ? mscnt - move : mscnt + move;
  wire logic next_index = next_mscnt == SID_MSCNT_ZERO;

  // stall threshold from reference pulse width and sensitivity
  wire logic [9:0] sens_thr = 10'(load_ref_pulse_width_i >> SID_SENS_SHIFT)
    + {2'h0, ~load_mode_stall_sens_i};
  wire logic stall_reached = stall_cnt >= sens_thr;
  wire logic stall_clear = ~load_active_q | motor_ready_i;
  wire logic [4:0] src_vec = {standstill, skip_tgl, chop_on, index_q, stall};

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_s1 <= 1'b0;
      step_s2 <= 1'b0;
      step_s3 <= 1'b0;
    end else begin
      step_s1 <= step_i;
      step_s2 <= step_s1;
      step_s3 <= step_s2;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir_s1 <= 1'b0;
      dir_s2 <= 1'b0;
    end else begin
      dir_s1 <= dir_i;
      dir_s2 <= dir_s1;
    end
  end

  // step interval measurement
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      itv_cnt <= '0;
    end else if (step_edge) begin
      itv_cnt <= '0;
    end else if (!st_expired) begin
      itv_cnt <= itv_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_itv <= '1;
    end else if (step_edge) begin
      last_itv <= itv_cnt;
    end else if (st_expired) begin
      last_itv <= '1;
    end
  end

  // standstill timeout, cleared by the next active edge
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      standstill <= 1'b0;
    end else if (step_edge) begin
      standstill <= 1'b0;
    end else if (st_expired) begin
      standstill <= 1'b1;
    end
  end

  // interpolated microstep generator
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sub_cnt <= '0;
      ms_left <= '0;
    end else if (step_edge & interp) begin
      ms_left <= step_width;
      sub_cnt <= '0;
    end else if (sub_tick) begin
      ms_left <= ms_left - 1'b1;
      sub_cnt <= '0;
    end else begin
      sub_cnt <= sub_cnt + 1'b1;
    end
  end

  // microstep counter position
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mscnt <= SID_MSCNT_ZERO;
    end else if (do_move) begin
      mscnt <= next_mscnt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      index_q <= 1'b0;
    end else if (do_move) begin
      index_q <= next_index;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      skip_tgl <= 1'b0;
    end else if (skip_step) begin
      skip_tgl <= ~skip_tgl;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      microstep_o <= 1'b0;
    end else begin
      microstep_o <= do_move;
    end
  end

  // chopper on-state alternates between the two coils
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chop_sel <= 1'b0;
      chop_on <= 1'b0;
    end else begin
      chop_sel <= ~chop_sel;
      chop_on <= chop_sel ? coil_b_on_i : coil_a_on_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_value <= '0;
    end else begin
      load_value <= load_value_i[8:0];
    end
  end

  // load-dependent commutation and fullstep switching
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_active_q <= 1'b0;
      fullstep_q <= 1'b0;
    end else begin
      load_active_q <= load_enter;
      fullstep_q <= load_enter;
    end
  end

  // holding current while at standstill
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_q <= '0;
    end else begin
      cur_q <= standstill ? holding_current_i : run_current_i;
    end
  end

  // blocked motor: not-ready cycles counted against the threshold
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stall_cnt <= '0;
      stall <= 1'b0;
    end else if (stall_clear) begin
      stall_cnt <= '0;
      stall <= 1'b0;
    end else if (stall_reached) begin
      stall <= 1'b1;
    end else begin
      stall_cnt <= stall_cnt + 1'b1;
    end
  end

  sid_diag_pin u_diag0 (
    .src_sel_i(diag0_src_i),
    .src_vec_i(src_vec),
    .push_pull_i(diag0_pp_i),
    .force_low_i(por_active_i),
    .pin_o(diag_out_zero_o),
    .pin_oe_o(diag_out_zero_oe_o)
  );

  sid_diag_pin u_diag_out_one (
    .src_sel_i(diag_out_one_src_i),
    .src_vec_i(src_vec),
    .push_pull_i(diag_out_one_pp_i),
    .force_low_i(1'b0),
    .pin_o(diag_out_one_o),
    .pin_oe_o(diag_out_one_oe_o)
  );

  assign mscnt_o = mscnt;
  assign standstill_o = standstill;
  assign current_setpoint_o = cur_q;
  assign load_mode_active_o = load_active_q;
  assign fullstep_o = fullstep_q;
  assign eff_off_time_o = (load_active_q && off_time_i > SID_OFF_TIME_LOAD_MAX)
    ? SID_OFF_TIME_LOAD_MAX : off_time_i;
  assign load_value_o = load_value;
  assign stall_o = stall;
endmodule // sid_step_interpolator

// File: tb/sid_step_interpolator_checker.sv
// assertion checker bound to the step interpolator
`timescale 1ns/1ps
module sid_step_interpolator_checker
  import sid_pkg::*;
#(parameter int STST_LOG2 = 8, parameter int STST_FAST_LOG2 = 6) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic por_active_i,
  input wire logic step_i,
  input wire logic fast_standstill_i,
  input wire logic quiet_chop_en_i,
  input wire logic [4:0] holding_current_i,
  input wire logic [3:0] off_time_i,
  input wire logic [22:0] min_commutation_velocity_i,
  input wire logic standstill_o,
  input wire logic [4:0] current_setpoint_o,
  input wire logic load_mode_active_o,
  input wire logic [3:0] eff_off_time_o,
  input wire logic diag_out_zero_o,
  input wire logic diag_out_zero_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic stp_q;
  logic [11:0] idle;
  // cycles since the last rising step pin edge
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stp_q <= 1'b0;
      idle <= 12'h000;
    end else begin
      stp_q <= step_i;
      idle <= (step_i && !stp_q) ? 12'h000 : idle + 12'h001;
    end
  end
  a_por_pull_low: assert property (por_active_i |->
    diag_out_zero_oe_o && !diag_out_zero_o) else $error("diag zero high");
  a_stst_early: assert property ($rose(standstill_o) |-> idle >=
    (fast_standstill_i ? 1 << STST_FAST_LOG2 : 1 << STST_LOG2))
    else $error("standstill early");
  a_stst_late: assert property (idle == (1 << STST_LOG2) + 10
    |-> standstill_o) else $error("standstill late");
  a_stst_clear: assert property (standstill_o && step_i && !stp_q
    |-> ##[1:4] !standstill_o) else $error("standstill kept");
  a_hold_current: assert property ($rose(standstill_o) |-> ##[0:2]
    current_setpoint_o == holding_current_i) else $error("no hold current");
  a_quiet_off: assert property (quiet_chop_en_i [*2] |->
    !load_mode_active_o) else $error("load mode with quiet chopper");
  a_vmin_zero: assert property (
    (min_commutation_velocity_i == '0) [*2] |-> !load_mode_active_o)
    else $error("load mode with zero velocity");
  a_off_time_clamp: assert property (load_mode_active_o |->
    eff_off_time_o == (off_time_i > SID_OFF_TIME_LOAD_MAX ?
    SID_OFF_TIME_LOAD_MAX : off_time_i)) else $error("off time not clamped");
  c_stst: cover property ($rose(standstill_o));
  c_load: cover property ($rose(load_mode_active_o));
  c_por: cover property (por_active_i);
endmodule // sid_step_interpolator_checker

bind sid_step_interpolator sid_step_interpolator_checker #(
  .STST_LOG2(STST_LOG2), .STST_FAST_LOG2(STST_FAST_LOG2)) u_chk (.*);

// File: tb/sid_ctrl_model.sv
// motion controller model sending step and direction
`timescale 1ns/1ps
module sid_ctrl_model (
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic dir_req_i,
  input wire logic [11:0] half_i,
  output logic step_o,
  output logic dir_o,
  output logic busy_o
);
  initial begin
    step_o = 1'b0;
    dir_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge mclk_i);
      if (go_i) begin
        #1 busy_o = 1'b1;
        dir_o = dir_req_i;
        repeat (2) @(posedge mclk_i);
        #1 step_o = 1'b1; // equal high and low time
        repeat (half_i) @(posedge mclk_i);
        #1 step_o = 1'b0;
        repeat (half_i) @(posedge mclk_i);
        #1 busy_o = 1'b0;
      end
    end
  end
endmodule // sid_ctrl_model

// File: tb/sid_step_interpolator_tb_top.sv
// testbench for the step interpolator and diagnostic pins
`timescale 1ns/1ps
module sid_step_interpolator_tb_top;
  import sid_pkg::*;
  logic mclk_i = '0, rst_n_i = '0, por_active_i = '0, intpol_en_i = '0;
  logic dedge_i = '0, fast_standstill_i = '0, quiet_chop_en_i = '0;
  logic load_mode_en_i = '0, vhigh_fs_i = '0, vhigh_chm_i = '0, d, v;
  logic motor_ready_i = '1, coil_a_on_i = '0, coil_b_on_i = '0;
  logic diag0_pp_i = '0, diag_out_one_pp_i = '0, go = '0, drq = '0, busy;
  logic step_i, dir_i, microstep_o, standstill_o, load_mode_active_o;
  logic fullstep_o, stall_o, diag_out_zero_o, diag_out_zero_oe_o;
  logic diag_out_one_o, diag_out_one_oe_o;
  logic [2:0] diag0_src_i = 3'h4, diag_out_one_src_i = 3'h4;
  logic [3:0] mres_i = '0, off_time_i = '0, eff_off_time_o;
  logic [4:0] run_current_i = 5'h1F, holding_current_i = 5'h06;
  logic [4:0] current_setpoint_o;
  logic [22:0] min_commutation_velocity_i = '0, velocity_i = '0;
  logic [9:0] load_ref_pulse_width_i = 10'h040, load_value_i = '0;
  logic [9:0] mscnt_o, ex;
  logic [7:0] load_mode_stall_sens_i = 8'hFF;
  logic [8:0] load_value_o;
  logic [16:0] lf = 17'h16065;
  logic [11:0] half = 12'h004;
  logic [9:0] q[$];
  int fail_count = 0, checked = 0, cyc = 0, pulses = 0;
  bit watch = 0;
  sid_step_interpolator #(.STST_LOG2(10), .STST_FAST_LOG2(7)) u_dut (.*);
  sid_ctrl_model u_ctrl (.mclk_i, .go_i(go), .dir_req_i(drq),
    .half_i(half), .step_o(step_i), .dir_o(dir_i), .busy_o(busy));
  function automatic logic [16:0] nx(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task miss();
    fail_count++;
    $display("unexpected at %0t: result mismatch", $time);
  endtask
  task chk(input logic ok);
    checked++;
    if (ok !== 1'b1) miss();
  endtask
  task close_out();
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task stp(input logic dd);
    #1 go = 1'b1;
    drq = dd;
    @(posedge mclk_i);
    #1 go = 1'b0;
    @(posedge mclk_i);
    while (busy) @(posedge mclk_i);
  endtask
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    #1 lf = nx(lf);
    if (cyc > 16) chk(load_value_o === load_value_i[8:0]);
    {coil_a_on_i, coil_b_on_i, off_time_i} = lf[5:0];
    load_value_i = lf[15:6];
    cyc++;
    if (cyc == 20000) begin
      miss();
      close_out();
    end
  end
  always @(posedge mclk_i) if (microstep_o === 1'b1) begin
    pulses++;
    if (watch) begin
      checked++;
      if (q.size() == 0 || q.pop_front() !== mscnt_o) miss();
    end
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    ex = '0;
    watch = 1;
    for (int m = 0; m < 10; m++) begin
      mres_i = m[3:0];
      repeat (2) begin
        d = lf[9];
        ex = d ? ex - (10'h001 << (m > 8 ? 8 : m))
          : ex + (10'h001 << (m > 8 ? 8 : m));
        q.push_back(ex);
        stp(d);
      end
    end
    #1 dedge_i = 1'b1;
    mres_i = 4'h2;
    repeat (2) begin
      ex = ex + 10'h004;
      q.push_back(ex);
    end
    stp(1'b0);
    #1 dedge_i = 1'b0;
    repeat (4) @(posedge mclk_i);
    watch = 0;
    chk(q.size() == 0);
    #1 intpol_en_i = 1'b1;
    mres_i = 4'h4;
    pulses = 0;
    half = 12'h12C;
    repeat (6) stp(1'b0);
    repeat (200) @(posedge mclk_i);
    chk(pulses == 96);
    ex = ex + 10'h060;
    chk(mscnt_o === ex);
    repeat (1100) @(posedge mclk_i);
    chk(standstill_o === 1'b1);
    chk(current_setpoint_o === holding_current_i);
    #1 diag_out_one_pp_i = 1'b1;
    @(posedge mclk_i);
    chk(diag_out_one_o === 1'b1 && diag_out_one_oe_o === 1'b1);
    #1 diag_out_one_pp_i = 1'b0;
    por_active_i = 1'b1;
    diag0_pp_i = 1'b1;
    diag0_src_i = SID_SRC_INDEX;
    @(posedge mclk_i);
    chk(diag_out_one_oe_o === 1'b1 && diag_out_one_o === 1'b0);
    chk(diag_out_zero_oe_o === 1'b1 && diag_out_zero_o === 1'b0);
    #1 por_active_i = 1'b0;
    fast_standstill_i = 1'b1;
    intpol_en_i = 1'b0;
    half = 12'h004;
    stp(1'b0);
    ex = ex + 10'h010;
    chk(standstill_o === 1'b0);
    chk(diag_out_zero_o === (mscnt_o == SID_MSCNT_ZERO));
    repeat (140) @(posedge mclk_i);
    chk(standstill_o === 1'b1);
    #1 load_mode_en_i = 1'b1;
    vhigh_fs_i = 1'b1;
    vhigh_chm_i = 1'b1;
    min_commutation_velocity_i = {7'h00, lf[15:0]} | 23'h000001;
    velocity_i = 23'h7FFFFF;
    motor_ready_i = 1'b0;
    diag_out_one_src_i = SID_SRC_SKIP;
    diag_out_one_pp_i = 1'b1;
    repeat (30) @(posedge mclk_i);
    chk(load_mode_active_o === 1'b1 && fullstep_o === 1'b1);
    chk(stall_o === 1'b1);
    v = diag_out_one_o;
    stp(1'b1);
    repeat (4) @(posedge mclk_i);
    chk(diag_out_one_o === ~v);
    chk(mscnt_o === ex);
    #1 quiet_chop_en_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    chk(load_mode_active_o === 1'b0);
    #1 quiet_chop_en_i = 1'b0;
    min_commutation_velocity_i = '0;
    repeat (3) @(posedge mclk_i);
    chk(load_mode_active_o === 1'b0);
    close_out();
  end
endmodule // sid_step_interpolator_tb_top
